/* rtl/serial_shift_pkg.sv */
// Package with register map, field positions and timing for the serial shift unit
// Summary of operation
// - Two-wire signalling, no slew limit or filter
// - Start detected sets start flag
// - Hold clock low after start falling edge
// - Slave samples data on rising clock
// - Overflow after eight bits holds clock low in two-wire hold mode only
// - Read bit one: slave drives data
// - Start detector delays data 50 ns (two core clocks)
// - Start detector active only two-wire mode
// - Start detection sampled on the core clock
// - Counter counts both external clock edges
// - Counter at F overflows on one edge
// - Software strobe can overflow counter
// - Write beats coincident shift
// - Left shift, clock chosen by select field
// - Mode zero still samples and shifts
// - Bit 7 reaches pin through latch
// - Transfer end copies shift into buffer
// - Overflow flag set on wrap, write-one clears
// - Start flag write-one clears, releases hold
// - Stop flag set on stop, write-one clears
package serial_shift_pkg;

  localparam logic [3:0] addr_data    = 4'h0;
  localparam logic [3:0] addr_buffer  = 4'h4;
  localparam logic [3:0] addr_status  = 4'h8;
  localparam logic [3:0] addr_control = 4'hc;

  localparam int st_start = 7;
  localparam int st_ovf   = 6;
  localparam int st_stop  = 5;
  localparam int st_coll  = 4;

  localparam int cr_wm_hi  = 5;
  localparam int cr_wm_lo  = 4;
  localparam int cr_cs_hi  = 3;
  localparam int cr_cs_lo  = 2;
  localparam int cr_strobe = 1;
  localparam int cr_toggle = 0;

  localparam logic [7:0] data_reset    = 8'h00;
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [3:0] count_max     = 4'hf;
  localparam logic [3:0] count_reset   = 4'h0;

  localparam int clk_period_ns   = 25;
  localparam int sda_delay_min_ns = 50;
  localparam int sda_delay_cycles = (sda_delay_min_ns + clk_period_ns - 1) / clk_period_ns;

  typedef enum logic [1:0] { wm_off, wm_three, wm_two, wm_two_hold } wire_mode_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
    logic do_o;
  } pin_out_t;

endpackage : serial_shift_pkg

/* rtl/serial_shift_two_wire.sv */
// Serial shift unit with two-wire start detector and Avalon-MM registers
`timescale 1ns/10ps
module serial_shift_two_wire (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic [3:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      timer_match,
  input  wire logic                      three_wire_clock_pin,
  input  wire logic                      serial_data_in_pin,
  output serial_shift_pkg::pin_out_t     pins,
  output logic                           start_irq,
  output logic                           overflow_irq
);

  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic       scl_q;
  logic [serial_shift_pkg::sda_delay_cycles-1:0] sda_dly_q;
  logic [7:0] shift_q;
  logic [7:0] buffer_q;
  logic [3:0] count_q;
  logic [7:0] control_q;
  logic       start_flag_q;
  logic       ovf_flag_q;
  logic       stop_flag_q;
  logic       start_hold_q;
  logic       latch_q;
  logic       sie_q;
  logic       oie_q;

  // Pin inputs pass two flops before use
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
    end else begin
      scl_s_q <= {scl_s_q[0], three_wire_clock_pin};
      sda_s_q <= {sda_s_q[0], serial_data_in_pin};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_q     <= 1'b1;
      sda_dly_q <= '1;
    end else begin
      scl_q     <= scl_s_q[1];
      sda_dly_q <= {sda_dly_q[serial_shift_pkg::sda_delay_cycles-2:0], sda_s_q[1]};
    end
  end

  wire wm_hi     = control_q[serial_shift_pkg::cr_wm_hi];
  wire wm_lo     = control_q[serial_shift_pkg::cr_wm_lo];
  wire cs_hi     = control_q[serial_shift_pkg::cr_cs_hi];
  wire cs_lo     = control_q[serial_shift_pkg::cr_cs_lo];
  wire two_wire  = wm_hi;
  wire hold_ovf  = wm_hi & wm_lo;

  wire scl_rise  = scl_s_q[1] & ~scl_q;
  wire scl_fall  = ~scl_s_q[1] & scl_q;
  wire sda_old   = sda_dly_q[serial_shift_pkg::sda_delay_cycles-1];
  // Delayed data against settled clock avoids false starts on clock skew
  // Sampled on clk: wake from a stopped clock is not covered
  wire start_det = two_wire & scl_s_q[1] & ~sda_s_q[1] & sda_old;
  wire stop_det  = two_wire & scl_s_q[1] & sda_s_q[1] & ~sda_old;

  // Bus decode
  wire bus_wr    = avs_write;
  wire wr_data   = bus_wr & (avs_address == serial_shift_pkg::addr_data);
  wire wr_status = bus_wr & (avs_address == serial_shift_pkg::addr_status);
  wire wr_ctrl   = bus_wr & (avs_address == serial_shift_pkg::addr_control);
  wire [7:0] wd  = avs_writedata[7:0];
  wire sw_strobe = wr_ctrl & wd[serial_shift_pkg::cr_strobe];
  wire sw_toggle = wr_ctrl & wd[serial_shift_pkg::cr_toggle];
  // Select bit acts in the very write that carries it
  wire clk_strb  = wr_ctrl ? wd[serial_shift_pkg::cr_strobe] : control_q[serial_shift_pkg::cr_strobe];

  // Clock source selection; both external edges advance the counter while the strobe bit is clear, the toggle strobe while it is set
  wire ext_edge  = scl_rise | scl_fall;
  wire ext_shift = cs_lo ? scl_fall : scl_rise;
  wire shift_en  = cs_hi ? ext_shift
                         : (cs_lo ? timer_match : sw_strobe);
  wire count_en  = cs_hi ? (clk_strb ? sw_toggle : ext_edge)
                         : (cs_lo ? timer_match : sw_strobe);
  wire wrap      = count_en & (count_q == serial_shift_pkg::count_max);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_q <= serial_shift_pkg::data_reset;
    end else if (wr_data) begin
      shift_q <= wd;
    end else if (shift_en) begin
      shift_q <= {shift_q[6:0], sda_s_q[1]};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= serial_shift_pkg::count_reset;
    end else if (wr_status) begin
      count_q <= wd[3:0];
    end else if (count_en) begin
      count_q <= count_q + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buffer_q <= serial_shift_pkg::data_reset;
    end else if (wrap) begin
      buffer_q <= shift_en ? {shift_q[6:0], sda_s_q[1]} : shift_q;
    end
  end

  // Flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_flag_q <= 1'b0;
      ovf_flag_q   <= 1'b0;
      stop_flag_q  <= 1'b0;
    end else begin
      start_flag_q <= start_det | (start_flag_q & ~(wr_status & wd[serial_shift_pkg::st_start]));
      ovf_flag_q   <= wrap | (ovf_flag_q & ~(wr_status & wd[serial_shift_pkg::st_ovf]));
      stop_flag_q  <= stop_det | (stop_flag_q & ~(wr_status & wd[serial_shift_pkg::st_stop]));
    end
  end

  // Hold arms at the first falling clock edge after a start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_hold_q <= 1'b0;
    end else if (~two_wire | ~start_flag_q) begin
      start_hold_q <= 1'b0;
    end else if (scl_fall) begin
      start_hold_q <= 1'b1;
    end
  end

  // Output latch follows bit 7 in external mode while the clock is low with cs_lo clear, high with cs_lo set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_q <= 1'b1;
    end else if (~cs_hi | (scl_s_q[1] == cs_lo)) begin
      latch_q <= shift_q[7];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      control_q <= serial_shift_pkg::control_reset;
      sie_q     <= 1'b0;
      oie_q     <= 1'b0;
    end else if (wr_ctrl) begin
      control_q <= {2'h0, wd[5:1], 1'b0};
      sie_q     <= wd[7];
      oie_q     <= wd[6];
    end
  end

  // Toggle latch for the clock output, used by a master
  logic tog_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tog_q <= 1'b1;
    end else if (sw_toggle) begin
      tog_q <= ~tog_q;
    end
  end

  // Open-drain drive in two-wire mode; hold forces clock low
  wire scl_hold = start_hold_q | (hold_ovf & ovf_flag_q);
  always_comb begin
    pins.do_o   = latch_q;
    pins.sda_o  = 1'b0;
    pins.sda_oe = two_wire & ~latch_q;
    pins.scl_o  = two_wire ? 1'b0 : tog_q;
    pins.scl_oe = two_wire ? (scl_hold | ~tog_q) : (wm_lo & ~cs_hi);
  end

  assign start_irq    = start_flag_q & sie_q;
  assign overflow_irq = ovf_flag_q & oie_q;

  wire collision = two_wire & (shift_q[7] != sda_s_q[1]);

  // Zero wait state bus: answers in the request cycle
  assign avs_waitrequest = 1'b0;
  always_comb begin
    case (avs_address)
      serial_shift_pkg::addr_data:    avs_readdata = {24'h0, shift_q};
      serial_shift_pkg::addr_buffer:  avs_readdata = {24'h0, buffer_q};
      serial_shift_pkg::addr_status:  avs_readdata = {24'h0, start_flag_q, ovf_flag_q, stop_flag_q, collision, count_q};
      serial_shift_pkg::addr_control: avs_readdata = {24'h0, sie_q, oie_q, control_q[5:2], 2'h0};
      default:                        avs_readdata = 32'h0;
    endcase
  end

endmodule : serial_shift_two_wire

/* tb/shift_asserts.sv */
// Port checker for the serial shift unit
`timescale 1ns/10ps
module shift_asserts (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic [3:0]                 avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_writedata,
  input wire logic [31:0]                avs_readdata,
  input wire serial_shift_pkg::pin_out_t pins,
  input wire logic                       start_irq,
  input wire logic                       overflow_irq
);
  logic [7:0] ctl_q;
  always_ff @(posedge clk or posedge reset)
    if (reset)
      ctl_q <= 8'h00;
    else if (avs_write && avs_address == serial_shift_pkg::addr_control)
      ctl_q <= avs_writedata[7:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_hole; avs_read && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("hole read");
  property p_upper; avs_read |-> avs_readdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
  property p_strobe; avs_read && avs_address == 4'hc |-> avs_readdata[1:0] == 2'h0; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe read");
  property p_sclr; $fell(start_irq) |-> $past(avs_write); endproperty
  a_sclr: assert property (p_sclr) else $error("start flag lost");
  property p_oclr; $fell(overflow_irq) |-> $past(avs_write); endproperty
  a_oclr: assert property (p_oclr) else $error("ovf flag lost");
  property p_latch; avs_read && avs_address == 4'h0 && ctl_q[5:3] == 3'h2 |-> pins.do_o == avs_readdata[7]; endproperty
  a_latch: assert property (p_latch) else $error("latch");
  property p_sda; ctl_q[5] && pins.sda_oe |-> !pins.sda_o; endproperty
  a_sda: assert property (p_sda) else $error("data high");
  property p_scl; ctl_q[5] && pins.scl_oe |-> !pins.scl_o; endproperty
  a_scl: assert property (p_scl) else $error("clock high");
  c_start: cover property ($rose(start_irq));
  c_ovf: cover property ($rose(overflow_irq));
  c_hold: cover property ($rose(pins.scl_oe));
endmodule : shift_asserts
bind serial_shift_two_wire shift_asserts u_chk (.clk, .reset, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .pins, .start_irq, .overflow_irq);

/* tb/two_wire_master.sv */
// Two-wire bus master model that pulls lines low or releases them
`timescale 1ns/10ps
module two_wire_master (
  input  wire logic scl_line,
  output logic      scl_low,
  output logic      sda_low
);
  int timeouts = 0;
  initial begin
    scl_low = 0;
    sda_low = 0;
  end
  // Release, then wait out a stretching slave
  task automatic clk_high();
    int n;
    #3 scl_low = 0;
    for (n = 0; scl_line !== 1'b1 && n < 400; n++) #25;
    if (n == 400) timeouts++;
    #100;
  endtask : clk_high
  task automatic clk_low();
    #3 scl_low = 1;
    #100;
  endtask : clk_low
  task automatic bit_out(input logic b);
    sda_low = !b;
    #50;
    clk_high();
    clk_low();
  endtask : bit_out
  task automatic start_cond();
    sda_low = 0;
    clk_high();
    sda_low = 1;
    #100;
    clk_low();
  endtask : start_cond
  task automatic stop_cond();
    sda_low = 1;
    #50;
    clk_high();
    sda_low = 0;
    #100;
  endtask : stop_cond
endmodule : two_wire_master

/* tb/serial_shift_two_wire_tb.sv */
// Self-checking bench for the serial shift unit
`timescale 1ns/10ps
module serial_shift_two_wire_tb;
  logic                       clk, reset, avs_read, avs_write, timer_match, tm_req;
  logic                       avs_waitrequest, start_irq, overflow_irq, m_scl, m_sda;
  logic [3:0]                 avs_address;
  logic [31:0]                avs_writedata, avs_readdata;
  serial_shift_pkg::pin_out_t pins;
  logic [7:0]                 q;
  int                         fail_count = 0, checks_done = 0;
  // Pull-ups give the high level
  wire scl = !(m_scl | (pins.scl_oe & !pins.scl_o));
  wire sda = !(m_sda | (pins.sda_oe & !pins.sda_o));
  serial_shift_two_wire u_dut (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .timer_match, .three_wire_clock_pin(scl), .serial_data_in_pin(sda), .pins, .start_irq,
    .overflow_irq);
  two_wire_master u_master (.scl_line(scl), .scl_low(m_scl), .sda_low(m_sda));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    timer_match <= tm_req;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata[7:0];
    avs_write <= 0;
    avs_read <= 0;
    timer_match <= 0;
    if (n == 50) begin
      fail_count++;
      give_verdict();
    end
  endtask : bus
  task automatic test_regs();
    bus(0, 4'h8, 0); chk(q, 8'h00);
    bus(0, 4'h6, 0); chk(q, 8'h00);
    bus(1, 4'hc, 8'h10);
    bus(1, 4'h0, 8'h00); wt(2); chk({7'h0, pins.do_o}, 8'h00);
    bus(0, 4'h0, 0); chk(q, 8'h00);
    bus(1, 4'hc, 8'hc2);
    bus(0, 4'hc, 0); chk(q, 8'hc0);
    $display("registers done");
  endtask : test_regs
  task automatic test_counter();
    bus(1, 4'h8, 8'h4f);
    bus(1, 4'hc, 8'h42); wt(2); chk({7'h0, overflow_irq}, 8'h01);
    bus(1, 4'h8, 8'h4f);
    bus(1, 4'hc, 8'h48); u_master.clk_low(); wt(4); chk({7'h0, overflow_irq}, 8'h01);
    u_master.clk_high(); bus(0, 4'h8, 0); chk(q & 8'h0f, 8'h01);
    bus(1, 4'hc, 8'h04); bus(1, 4'h0, 8'h81);
    tm_req = 1; bus(0, 4'h8, 0); tm_req = 0;
    bus(0, 4'h0, 0); chk(q, 8'h03);
    tm_req = 1; bus(1, 4'h0, 8'h55); tm_req = 0;
    bus(0, 4'h0, 0); chk(q, 8'h55);
    $display("counter done");
  endtask : test_counter
  task automatic test_two_wire();
    logic [7:0] b = 8'ha5;
    bus(1, 4'hc, 8'h80); bus(1, 4'h8, 8'h80);
    u_master.start_cond(); wt(4); chk({7'h0, start_irq}, 8'h00);
    u_master.stop_cond();
    bus(1, 4'h0, 8'hff); bus(1, 4'hc, 8'hf8); bus(1, 4'h8, 8'hf0);
    u_master.start_cond(); wt(4); chk({6'h0, start_irq, pins.scl_oe}, 8'h03);
    bus(1, 4'h8, 8'h80); wt(4); chk({6'h0, start_irq, pins.scl_oe}, 8'h00);
    for (int i = 7; i >= 0; i--) u_master.bit_out(b[i]);
    wt(4); chk({6'h0, overflow_irq, pins.scl_oe}, 8'h03);
    bus(0, 4'h4, 0); chk(q, 8'ha5);
    bus(1, 4'h0, 8'h00); bus(1, 4'h8, 8'h4e); wt(4); chk({6'h0, sda, pins.scl_oe}, 8'h00);
    u_master.bit_out(1); wt(4); chk({6'h0, overflow_irq, pins.scl_oe}, 8'h03);
    bus(1, 4'h0, 8'hff); bus(1, 4'h8, 8'h4e);
    u_master.bit_out(1); bus(0, 4'h0, 0); chk(q, 8'hff);
    bus(1, 4'h8, 8'h40);
    u_master.stop_cond(); wt(4); bus(0, 4'h8, 0); chk(q & 8'h20, 8'h20);
    bus(1, 4'h8, 8'h20); bus(0, 4'h8, 0); chk(q & 8'h20, 8'h00);
    chk(u_master.timeouts[7:0], 8'h00);
    $display("two-wire done");
  endtask : test_two_wire
  initial begin
    reset = 1;
    {avs_read, avs_write, timer_match, tm_req, avs_address, avs_writedata} = '0;
    repeat (12) @(posedge clk);
    reset <= 0;
    test_regs();
    test_counter();
    test_two_wire();
    give_verdict();
  end
endmodule : serial_shift_two_wire_tb
